// File: rtl/ime_bit_engine.v
`include "ime_defs.vh"

// one bus symbol per request: start, stop, or one data bit (write or sample)
module ime_bit_engine (
	input wire clk,
	input wire rstn,
	input wire bitReq,
	input wire [1:0] bitKind,
	input wire bitOut,
	output reg bitDone,
	output reg bitIn,
	output reg sclOe,
	output reg sdaOe,
	input wire sdaIn
);
	// kinds: 0 data bit, 1 start, 2 stop
	localparam QTR = `IME_QTR_CYC;
	reg [15:0] cnt_r;
	reg [2:0] ph_r;
	reg busy_r;
	reg [1:0] kind_r;
	reg dat_r;
	wire tick = (cnt_r == QTR[15:0] - 16'h0001);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 16'h0000;
			ph_r <= 3'h0;
			busy_r <= 1'b0;
			kind_r <= 2'h0;
			dat_r <= 1'b1;
			bitDone <= 1'b0;
			bitIn <= 1'b1;
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
		end else begin
			bitDone <= 1'b0;
			if (!busy_r) begin
				cnt_r <= 16'h0000;
				ph_r <= 3'h0;
				if (bitReq) begin
					busy_r <= 1'b1;
					kind_r <= bitKind;
					dat_r <= bitOut;
				end
			end else begin
				cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
				if (tick) begin
					ph_r <= ph_r + 3'h1;
					case (kind_r)
					2'h1: begin
						// start: release sda with scl low, raise scl, pull sda low
						case (ph_r)
						3'h0: sdaOe <= 1'b0;
						3'h1: sclOe <= 1'b0;
						3'h2: sdaOe <= 1'b1; // R1
						3'h3: begin
							sclOe <= 1'b1;
							busy_r <= 1'b0;
							bitDone <= 1'b1;
						end
						default: ;
						endcase
					end
					2'h2: begin
						case (ph_r)
						3'h0: sdaOe <= 1'b1;
						3'h1: sclOe <= 1'b0;
						3'h2: begin
							sdaOe <= 1'b0; // R2
							busy_r <= 1'b0;
							bitDone <= 1'b1;
						end
						default: ;
						endcase
					end
					default: begin
						case (ph_r)
						3'h0: sdaOe <= ~dat_r;
						3'h1: sclOe <= 1'b0;
						3'h2: bitIn <= sdaIn;
						3'h3: begin
							sclOe <= 1'b1;
							busy_r <= 1'b0;
							bitDone <= 1'b1;
						end
						default: ;
						endcase
					end
					endcase
				end
			end
		end
	end
endmodule

// File: rtl/ime_defs.vh
`ifndef IME_DEFS_VH
`define IME_DEFS_VH

// command codes on cmdOp
`define IME_OP_START 4'h0
`define IME_OP_STOP 4'h1
`define IME_OP_RDBYTES 4'h2
`define IME_OP_WRBYTES 4'h3
`define IME_OP_READFROM 4'h4
`define IME_OP_WRITETO 4'h5
`define IME_OP_RDMEM 4'h6
`define IME_OP_WRMEM 4'h7
`define IME_OP_SCAN 4'h8

// bus timing
`define IME_CLK_HZ 50000000
`define IME_SCL_HZ 400000
`define IME_QTR_CYC (`IME_CLK_HZ / (`IME_SCL_HZ * 4))

// scan range and default memory address width
`define IME_SCAN_FIRST 7'h08
`define IME_SCAN_LAST 7'h77
`define IME_MADDR_DEF 6'h08

`endif

// File: rtl/ime_master.v
// What this block does
// (R1) start: sda falls while scl high
// (R2) stop: sda rises while scl high
// (R3) read count bytes, ack all but last
// (R4) last read byte: nack if option set
// (R5) write checks ack, stops on nack, counts
// (R6) addressed read, stop only if asked
// (R7) addressed read count equals buffer length
// (R8) addressed write: abandon on nack, counted
// (R9) memory access sends slave and memory address
// (R10) memory address width configurable, default eight
// (R11) memory read starts at given address
// (R12) memory write stores from given address
// (R13) scan probes 0x08..0x77, records acknowledgers
// (R14) no stop keeps bus for restart
// (R15) memory read: write address, restart, read
`include "ime_defs.vh"

module ime_master (
	input wire clk,
	input wire rstn,
	input wire cmdValid,
	input wire [3:0] cmdOp,
	input wire [6:0] cmdAddr,
	input wire [31:0] cmdMemAddr,
	input wire [5:0] cmdMemBits,
	input wire [7:0] cmdLen,
	input wire cmdNack,
	input wire cmdStop,
	output reg cmdReady,
	input wire [7:0] wrData,
	output reg wrTake,
	output reg [7:0] rdData,
	output reg rdValid,
	output reg [6:0] foundAddr,
	output reg foundValid,
	output reg [7:0] ackCount,
	output reg doneValid,
	output reg busOwned,
	output reg sclOut,
	output reg sclOe,
	input wire sclIn,
	output reg sdaOut,
	output reg sdaOe,
	input wire sdaIn
);
	localparam S_IDLE = 9'h001;
	localparam S_STA = 9'h002;
	localparam S_ADR = 9'h004;
	localparam S_MAD = 9'h008;
	localparam S_WR = 9'h010;
	localparam S_RD = 9'h020;
	localparam S_STO = 9'h040;
	localparam S_FIN = 9'h080;
	localparam S_WAIT = 9'h100;

	reg [8:0] st_r, ret_r;
	reg [3:0] op_r;
	reg [6:0] addr_r;
	reg [31:0] mad_r;
	reg [5:0] mbits_r;
	reg [7:0] len_r, ack_r;
	reg nack_r, stop_r, rw_r, restart_r;
	reg [8:0] sh_r;
	reg [3:0] bit_r;
	reg req_r;
	reg [1:0] kind_r;
	reg ackPh_r;
	// one symbol in flight at a time: a second request would latch a stale bit
	reg out_r;
	wire bitDone, bitIn, eSclOe, eSdaOe;

	ime_bit_engine u_bits (
		.clk(clk),
		.rstn(rstn),
		.bitReq(req_r),
		.bitKind(kind_r),
		.bitOut(sh_r[8]),
		.bitDone(bitDone),
		.bitIn(bitIn),
		.sclOe(eSclOe),
		.sdaOe(eSdaOe),
		.sdaIn(sdaIn)
	);

	wire isMem = (op_r == `IME_OP_RDMEM) || (op_r == `IME_OP_WRMEM);
	wire isRead = (op_r == `IME_OP_RDBYTES) || (op_r == `IME_OP_READFROM);
	wire lastByte = (len_r == 8'h01);
	// a zero memory width falls back to the default
	wire [5:0] mbits = (cmdMemBits == 6'h00) ? `IME_MADDR_DEF : cmdMemBits; // R10

	// issue one symbol; engine latches kind and data on the request
	task issue;
		input [1:0] k;
		begin
			req_r <= 1'b1;
			kind_r <= k;
			out_r <= 1'b1;
		end
	endtask

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= S_IDLE;
			ret_r <= S_IDLE;
			op_r <= 4'h0;
			addr_r <= 7'h00;
			mad_r <= 32'h0000_0000;
			mbits_r <= 6'h00;
			len_r <= 8'h00;
			ack_r <= 8'h00;
			nack_r <= 1'b1;
			stop_r <= 1'b1;
			rw_r <= 1'b0;
			restart_r <= 1'b0;
			sh_r <= 9'h1ff;
			bit_r <= 4'h0;
			req_r <= 1'b0;
			kind_r <= 2'h0;
			ackPh_r <= 1'b0;
			out_r <= 1'b0;
			cmdReady <= 1'b0;
			wrTake <= 1'b0;
			rdData <= 8'h00;
			rdValid <= 1'b0;
			foundAddr <= 7'h00;
			foundValid <= 1'b0;
			ackCount <= 8'h00;
			doneValid <= 1'b0;
			busOwned <= 1'b0;
			sclOut <= 1'b0;
			sclOe <= 1'b0;
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
		end else begin
			req_r <= 1'b0;
			wrTake <= 1'b0;
			rdValid <= 1'b0;
			foundValid <= 1'b0;
			doneValid <= 1'b0;
			cmdReady <= 1'b0;
			sclOe <= eSclOe;
			sdaOe <= eSdaOe;
			if (bitDone) begin
				out_r <= 1'b0;
			end
			case (st_r)
			S_IDLE: begin
				cmdReady <= 1'b1;
				if (cmdValid && cmdReady) begin
					cmdReady <= 1'b0;
					op_r <= cmdOp;
					addr_r <= (cmdOp == `IME_OP_SCAN) ? `IME_SCAN_FIRST : cmdAddr;
					mad_r <= cmdMemAddr;
					mbits_r <= mbits;
					len_r <= cmdLen;
					nack_r <= cmdNack;
					stop_r <= (cmdOp == `IME_OP_RDMEM || cmdOp == `IME_OP_WRMEM) ? 1'b1 : cmdStop;
					ack_r <= 8'h00;
					restart_r <= 1'b0;
					case (cmdOp)
					`IME_OP_STOP: begin
						issue(2'h2);
						st_r <= S_WAIT;
						ret_r <= S_FIN;
					end
					`IME_OP_RDBYTES: begin
						sh_r <= 9'h1ff;
						st_r <= (cmdLen == 8'h00) ? S_FIN : S_RD; // R3
						bit_r <= 4'h0;
						ackPh_r <= 1'b0;
					end
					`IME_OP_WRBYTES: begin
						st_r <= (cmdLen == 8'h00) ? S_FIN : S_WR;
						bit_r <= 4'h0;
						ackPh_r <= 1'b0;
						sh_r <= {wrData, 1'b1};
						wrTake <= (cmdLen != 8'h00);
					end
					default: begin
						// repeated start when the bus is still held
						issue(2'h1); // R14
						st_r <= S_WAIT;
						ret_r <= (cmdOp == `IME_OP_START) ? S_FIN : S_STA;
					end
					endcase
				end
			end
			S_WAIT: begin
				if (bitDone) begin
					st_r <= ret_r;
					busOwned <= (kind_r == 2'h1) ? 1'b1 : (kind_r == 2'h2) ? 1'b0 : busOwned;
					// scan: every probe after the first opens with its own start after the stop
					if (op_r == `IME_OP_SCAN && kind_r == 2'h2 && ret_r == S_STA) begin
						issue(2'h1); // R13
						st_r <= S_WAIT;
					end
				end
			end
			S_STA: begin
				// address phase; memory read writes first then restarts
				rw_r <= isRead || (op_r == `IME_OP_RDMEM && restart_r); // R15
				sh_r <= {addr_r, isRead || (op_r == `IME_OP_RDMEM && restart_r), 1'b1}; // R9
				bit_r <= 4'h0;
				ackPh_r <= 1'b0;
				st_r <= S_ADR;
			end
			S_ADR, S_MAD, S_WR: begin
				if (!out_r && !bitDone) begin
					issue(2'h0);
				end
				if (bitDone) begin
					if (!ackPh_r) begin
						sh_r <= {sh_r[7:0], 1'b1};
						bit_r <= bit_r + 4'h1;
						if (bit_r == 4'h7) begin
							ackPh_r <= 1'b1;
						end
					end else begin
						ackPh_r <= 1'b0;
						bit_r <= 4'h0;
						if (op_r == `IME_OP_SCAN) begin
							if (!bitIn) begin
								foundAddr <= addr_r; // R13
								foundValid <= 1'b1;
							end
							addr_r <= addr_r + 7'h01;
							issue(2'h2);
							st_r <= S_WAIT;
							ret_r <= (addr_r == `IME_SCAN_LAST) ? S_FIN : S_IDLE;
							if (addr_r != `IME_SCAN_LAST) begin
								ret_r <= S_STA;
								kind_r <= 2'h2;
							end
						end else if (bitIn) begin
							// nack: drop remaining bytes, stop still honoured
							len_r <= 8'h00; // R5 R8
							st_r <= stop_r ? S_STO : S_FIN;
						end else if (st_r == S_ADR) begin
							if (rw_r) begin
								st_r <= S_RD;
								sh_r <= 9'h1ff;
							end else if (isMem && !restart_r) begin
								st_r <= S_MAD; // R9 R12
								sh_r <= {mad_r[31:24], 1'b1};
								mad_r <= {mad_r[23:0], 8'h00};
								mbits_r <= mbits_r - 6'h08;
							end else if (len_r == 8'h00) begin
								st_r <= stop_r ? S_STO : S_FIN;
							end else begin
								st_r <= S_WR;
								sh_r <= {wrData, 1'b1};
								wrTake <= 1'b1;
							end
						end else if (st_r == S_MAD) begin
							if (mbits_r != 6'h00) begin
								sh_r <= {mad_r[31:24], 1'b1};
								mad_r <= {mad_r[23:0], 8'h00};
								mbits_r <= mbits_r - 6'h08;
							end else if (op_r == `IME_OP_RDMEM) begin
								restart_r <= 1'b1; // R11 R15
								issue(2'h1);
								st_r <= S_WAIT;
								ret_r <= S_STA;
							end else if (len_r == 8'h00) begin
								st_r <= S_STO;
							end else begin
								st_r <= S_WR;
								sh_r <= {wrData, 1'b1};
								wrTake <= 1'b1;
							end
						end else begin
							ack_r <= ack_r + 8'h01; // R5 R8
							len_r <= len_r - 8'h01;
							if (lastByte) begin
								st_r <= (stop_r && op_r != `IME_OP_WRBYTES) ? S_STO : S_FIN;
							end else begin
								sh_r <= {wrData, 1'b1};
								wrTake <= 1'b1;
							end
						end
					end
				end
			end
			S_RD: begin
				if (!out_r && !bitDone) begin
					issue(2'h0);
				end
				if (bitDone) begin
					if (!ackPh_r) begin
						rdData <= {rdData[6:0], bitIn};
						bit_r <= bit_r + 4'h1;
						if (bit_r == 4'h7) begin
							ackPh_r <= 1'b1;
							rdValid <= 1'b1;
							// ack all but last; last nacks per option or end of read
							sh_r[8] <= lastByte ? (op_r == `IME_OP_RDBYTES ? nack_r : 1'b1) : 1'b0; // R3 R4 R6 R7
						end
					end else begin
						ackPh_r <= 1'b0;
						bit_r <= 4'h0;
						sh_r <= 9'h1ff;
						len_r <= len_r - 8'h01;
						if (lastByte) begin
							st_r <= (stop_r && op_r != `IME_OP_RDBYTES) ? S_STO : S_FIN; // R6
						end
					end
				end
			end
			S_STO: begin
				issue(2'h2); // R2
				st_r <= S_WAIT;
				ret_r <= S_FIN;
			end
			default: begin
				ackCount <= ack_r;
				doneValid <= 1'b1;
				st_r <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// File: tb/ime_master_properties.sv
`include "ime_defs.vh"

module ime_master_properties (
	input wire clk,
	input wire rstn,
	input wire cmdValid,
	input wire [3:0] cmdOp,
	input wire [7:0] cmdLen,
	input wire cmdReady,
	input wire rdValid,
	input wire [6:0] foundAddr,
	input wire foundValid,
	input wire doneValid,
	input wire busOwned,
	input wire sclOut,
	input wire sclOe,
	input wire sdaOut,
	input wire sdaOe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_start_owns:
	assert property ($rose(sdaOe) && !sclOe |-> ##[0:130] busOwned)
		else $error("start without bus");
	a_stop_frees:
	assert property ($fell(sdaOe) && !sclOe |-> ##[0:130] !busOwned)
		else $error("stop kept bus");
	a_drive_low:
	assert property (sclOut == 1'b0 && sdaOut == 1'b0)
		else $error("line driven high");
	a_clock_owned:
	assert property ($rose(sclOe) |-> busOwned)
		else $error("clock while free");
	a_read_owned:
	assert property (rdValid |-> busOwned && !cmdReady)
		else $error("read byte outside transfer");
	a_zero_len:
	assert property (cmdValid && cmdReady && cmdOp == `IME_OP_RDBYTES && cmdLen == 8'h00
		|-> ##[1:4] doneValid) else $error("empty read hung");
	a_found_range:
	assert property (foundValid |-> foundAddr >= `IME_SCAN_FIRST && foundAddr <= `IME_SCAN_LAST)
		else $error("scan out of range");
	a_done_pulse:
	assert property (doneValid |=> !doneValid)
		else $error("done too long");
endmodule

// File: tb/ime_slave_model.sv
module ime_slave_model #(
	parameter [6:0] SLV_ADDR = 7'h50
) (
	input wire scl,
	input wire sda,
	input wire [7:0] ackLimit,
	output reg sdaOe
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] mem [0:255];
	reg [7:0] ptr, rxSh, txSh, idx;
	reg [3:0] bitNum;
	reg act, sel, rd;
	integer i;
	initial begin
		{sdaOe, act, sel, rd, ptr, idx, bitNum} = 0;
		for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5a;
	end
	always @(negedge sda) if (scl) begin
		{act, bitNum, idx, sel, rd} = {1'b1, 4'h0, 8'h00, 2'b00};
	end
	always @(posedge sda) if (scl) act = 0;
	always @(posedge scl) if (act) begin
		if (bitNum < 8) rxSh = {rxSh[6:0], sda};
		else if (rd && sda) sel = 0;
		bitNum = bitNum + 1;
	end
	// data changes only while scl is low, so nothing here mimics start or stop
	always @(negedge scl) if (act) begin
		sdaOe = 0;
		if (bitNum == 9) begin
			bitNum = 0;
			idx = idx + 1;
		end
		if (bitNum == 8 && idx == 0) begin
			sel = rxSh[7:1] == SLV_ADDR;
			rd = rxSh[0];
			sdaOe = sel;
		end else if (bitNum == 8 && !rd && sel && idx <= ackLimit) begin
			sdaOe = 1;
			if (idx == 1) ptr = rxSh;
			else begin
				mem[ptr] = rxSh;
				ptr = ptr + 1;
			end
		end else if (bitNum < 8 && rd && sel && idx > 0) begin
			if (bitNum == 0) begin
				txSh = mem[ptr];
				ptr = ptr + 1;
			end
			sdaOe = !txSh[7 - bitNum];
		end
	end
endmodule

// File: tb/tb_ime_master.sv
module tb_ime_master;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk = 0, rstn = 0, cmdValid = 0, cmdNack = 0, cmdStop = 0;
	reg [3:0] cmdOp = 0;
	reg [31:0] cmdMemAddr = 0;
	reg [5:0] cmdMemBits = 0;
	reg [7:0] cmdLen = 0, wrData = 0, ackLimit = 8'hff, d, r, img [0:255];
	reg [8:0] a;
	wire cmdReady, wrTake, rdValid, foundValid, doneValid, busOwned;
	wire sclOut, sclOe, sdaOut, sdaOe, slvOe;
	wire [7:0] rdData, ackCount;
	wire [6:0] foundAddr;
	// both lines have pull-ups: low only while some party pulls
	wire scl = !sclOe;
	wire sda = !sdaOe && !slvOe;
	reg [7:0] wrQ[$], rdQ[$];
	reg [8:0] ackQ[$];
	int num_errors = 0, check_count = 0, i;
	ime_master dut (.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdAddr(7'h50), .cmdMemAddr(cmdMemAddr), .cmdMemBits(cmdMemBits), .cmdLen(cmdLen),
		.cmdNack(cmdNack), .cmdStop(cmdStop), .cmdReady(cmdReady), .wrData(wrData),
		.wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .foundAddr(foundAddr),
		.foundValid(foundValid), .ackCount(ackCount), .doneValid(doneValid),
		.busOwned(busOwned), .sclOut(sclOut), .sclOe(sclOe), .sclIn(scl),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .sdaIn(sda));
	ime_slave_model slv (.scl(scl), .sda(sda), .ackLimit(ackLimit), .sdaOe(slvOe));
	initial forever #10 clk = ~clk;
	task wrap_up;
		if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task bad(input string m);
		$display("MISMATCH %0t %s", $time, m);
		num_errors++;
	endtask
	task put(input [7:0] b);
		wrQ.push_back(b);
		wrData = wrQ[0];
	endtask
	task exp_rd(input [7:0] p, input int n);
		for (int j = 0; j < n; j++) rdQ.push_back(img[p + j]);
	endtask
	// ak bit 8 set: count not checked
	task cmd(input [3:0] op, input [7:0] n, input nk, st, input [7:0] ma, input [8:0] ak);
		int k;
		begin
			ackQ.push_back(ak);
			{cmdOp, cmdLen, cmdNack, cmdStop, cmdMemAddr} = {op, n, nk, st, ma, 24'h0};
			cmdValid = 1;
			k = 0;
			// ready is registered: look at it settled, the accepting edge follows
			while (cmdReady !== 1 && k < 99) begin
				@(posedge clk);
				#2 k++;
			end
			@(posedge clk);
			#2 cmdValid = 0;
			do begin
				@(posedge clk);
				#2 k++;
			end while (doneValid !== 1 && k < 20000);
			if (k >= 20000) begin
				bad("timeout");
				wrap_up;
			end
		end
	endtask
	always @(posedge clk) begin
		#2;
		if (wrTake === 1) begin
			if (wrQ.size()) void'(wrQ.pop_front());
			if (wrQ.size()) wrData = wrQ[0];
		end
	end
	always @(posedge clk) begin
		#1;
		if (rdValid === 1) begin
			r = rdQ.size() ? rdQ.pop_front() : 8'hxx;
			check_count++;
			if (r !== rdData) bad("read data");
		end
		if (doneValid === 1) begin
			a = ackQ.size() ? ackQ.pop_front() : 9'h0xx;
			check_count++;
			if (a[8] !== 1 && a[7:0] !== ackCount) bad("ack count");
		end
	end
	initial begin
		for (i = 0; i < 256; i++) img[i] = i[7:0] ^ 8'h5a;
		i = $urandom(32'hf85f);
		repeat (5) @(posedge clk);
		#2 rstn = 1;
		repeat (2) @(posedge clk);
		#2 cmd(2, 0, 0, 0, 0, 9'h100);
		for (i = 0; i < 3; i++) begin
			d = $urandom;
			put(d);
			img[8'h20 + i] = d;
		end
		cmd(7, 3, 0, 1, 8'h20, 9'h100);
		exp_rd(8'h20, 3);
		cmdMemBits = 6'h08;
		cmd(6, 3, 0, 1, 8'h20, 9'h100);
		cmdMemBits = 6'h00;
		put(8'h40);
		for (i = 0; i < 2; i++) begin
			d = $urandom;
			put(d);
			img[8'h40 + i] = d;
		end
		cmd(5, 3, 0, 0, 0, 9'h003);
		check_count++;
		if (busOwned !== 1) bad("bus released");
		exp_rd(8'h42, 4);
		cmd(4, 4, 0, 1, 0, 9'h100);
		check_count++;
		if (busOwned !== 0) bad("bus kept");
		ackLimit = 8'h01;
		put(8'h60);
		put(8'h11);
		put(8'h22);
		cmd(5, 3, 0, 1, 0, 9'h001);
		wrQ.delete();
		ackLimit = 8'hff;
		cmd(0, 0, 0, 0, 0, 9'h100);
		put(8'ha0);
		put(8'h60);
		cmd(3, 2, 0, 0, 0, 9'h002);
		cmd(0, 0, 0, 0, 0, 9'h100);
		put(8'ha1);
		cmd(3, 1, 0, 0, 0, 9'h001);
		exp_rd(8'h60, 2);
		cmd(2, 2, 0, 0, 0, 9'h100);
		exp_rd(8'h62, 1);
		cmd(2, 1, 1, 0, 0, 9'h100);
		cmd(1, 0, 0, 0, 0, 9'h100);
		cmd(0, 0, 0, 0, 0, 9'h100);
		put(8'hfe);
		put(8'h33);
		cmd(3, 2, 0, 0, 0, 9'h000);
		wrQ.delete();
		cmd(1, 0, 0, 0, 0, 9'h100);
		repeat (3) @(posedge clk);
		check_count++;
		if (rdQ.size() || ackQ.size()) bad("results missing");
		wrap_up;
	end
endmodule

bind ime_master ime_master_properties u_props (.clk(clk), .rstn(rstn),
	.cmdValid(cmdValid), .cmdOp(cmdOp), .cmdLen(cmdLen), .cmdReady(cmdReady),
	.rdValid(rdValid), .foundAddr(foundAddr), .foundValid(foundValid),
	.doneValid(doneValid), .busOwned(busOwned), .sclOut(sclOut), .sclOe(sclOe),
	.sdaOut(sdaOut), .sdaOe(sdaOe));
